// ---- rtl/csr_pkg.sv ----
// constants and types for the chip-select and ready generator.
// assumes a 40 MHz clock and an APB register port with 32-bit data.
package csr_pkg;
  // register byte offsets
  localparam logic [7:0] REG_UPPER = 8'h00;
  localparam logic [7:0] REG_LOWER = 8'h04;
  localparam logic [7:0] REG_PBASE = 8'h08;
  localparam logic [7:0] REG_MBASE = 8'h0c;
  localparam logic [7:0] REG_MSIZE = 8'h10;
  localparam logic [7:0] REG_PMODE = 8'h14;
  localparam logic [7:0] REG_RELOC = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;
  localparam logic [7:0] REG_ENH = 8'h20;
  // reset values
  localparam logic [15:0] UPPER_RST = 16'hfffb;
  localparam logic [15:0] RELOC_RST = 16'h00ff;
  // field positions
  localparam int F_IGN = 2;
  localparam int F_LATCH = 6;
  localparam int F_IO = 7;
  localparam int F_RELOC_MEM = 12;
  localparam int F_ENH_NPS = 0;
  // programmed-flag indices
  localparam int P_UPPER = 0;
  localparam int P_LOWER = 1;
  localparam int P_MBASE = 2;
  localparam int P_MSIZE = 3;
  localparam int P_PBASE = 4;
  localparam int P_PMODE = 5;
  // decode geometry
  localparam logic [19:0] MID_MIN = 20'h02000;
  localparam logic [4:0] MID_QSHIFT = 5'h0b;
  localparam logic [19:0] PER_SPAN = 20'h00380;
  localparam logic [19:0] NPS_LO = 20'h000f8;
  localparam logic [19:0] NPS_HI = 20'h000ff;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } csr_state_t;

  // one bus cycle from the bus unit, cpu, dma or refresh unit
  typedef struct packed {
    logic [19:0] addr;
    logic io;
    logic refresh;
    logic dma;
  } csr_cyc_t;
endpackage : csr_pkg

// ---- rtl/csr_top.sv ----
// chip-select and ready generator with apb control registers.
// assumes bus cycles arrive on clk as a start pulse with csr_cyc_t;
// pins (ready, straps, coprocessor lines) are asynchronous.
module csr_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cyc_start,
  input wire csr_pkg::csr_cyc_t cyc,
  output logic cyc_ready,
  output logic ctl_hit,
  input wire logic ext_ready_in,
  input wire logic coproc_busy_in,
  input wire logic upper_mem_select_n_in,
  output logic upper_mem_select_n_out,
  output logic upper_mem_select_n_oe,
  input wire logic lower_mem_select_n_in,
  output logic lower_mem_select_n_out,
  output logic lower_mem_select_n_oe,
  input wire logic [3:0] mid_range_select_n_in,
  output logic [3:0] mid_range_select_n_out,
  output logic [3:0] mid_range_select_n_oe,
  output logic [6:0] periph_select_n,
  output logic periph_select_oe,
  output logic [1:0] addr_latch,
  output logic enhanced,
  output logic pin_float_test_mode
);
  csr_pkg::csr_state_t st_reg, st_next;
  logic [15:0] upper_reg, upper_next, lower_reg, lower_next;
  logic [15:0] pbase_reg, pbase_next, mbase_reg, mbase_next;
  logic [15:0] msize_reg, msize_next, pmode_reg, pmode_next;
  logic [15:0] reloc_reg, reloc_next, enh_reg, enh_next;
  logic [5:0] prog_reg, prog_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [1:0] cnt_reg, cnt_next;
  logic ign_reg, ign_next, done_reg, done_next, ctl_reg, ctl_next;
  logic up_reg, up_next, lo_reg, lo_next;
  logic [3:0] mid_reg, mid_next;
  logic [6:0] per_reg, per_next;
  logic [1:0] alat_reg, alat_next;
  logic float_reg, float_next, strap_reg, strap_next;
  logic arm_reg, arm_next, enh_mode_reg, enh_mode_next;
  logic oe_reg, oe_next;
  logic [1:0] cp_oe_reg, cp_oe_next;
  // synchronisers; the strap chain runs through reset so it holds
  // the pin level seen during reset at the first edge after release
  logic rdy_s1, rdy_s2, busy_s1, busy_s2;
  logic up_s1, up_s2, lo_s1, lo_s2;
  logic [1:0] cp_s1, cp_s2;

  logic acc, wr;
  logic up_hit, lo_hit, mid_hit, per_hit, ctl_h, nps_hit;
  logic [19:0] moff, msize, poff;
  logic [1:0] midx;
  logic [2:0] pidx;
  logic [1:0] w_sel;
  logic i_sel, done_c;
  logic [3:0] mid_dec;
  logic [6:0] per_dec;
  logic [15:0] rd;
  logic hit_any;

  assign acc = psel & penable & pready_reg;
  assign wr = acc & pwrite;

  // address decode of the incoming bus cycle
  always_comb begin
    up_hit = prog_reg[csr_pkg::P_UPPER] & ~cyc.io & (cyc.addr[19:10] >= upper_reg[15:6]);
    lo_hit = prog_reg[csr_pkg::P_LOWER] & ~cyc.io & (cyc.addr[19:10] <= lower_reg[15:6]) & ~up_hit;
    moff = cyc.addr - {mbase_reg[15:9], 13'h0000};
    msize = csr_pkg::MID_MIN << msize_reg[10:8];
    mid_hit = prog_reg[csr_pkg::P_MBASE] & prog_reg[csr_pkg::P_MSIZE] & ~cyc.io
      & (moff < msize) & ~up_hit & ~lo_hit;
    midx = 2'(moff >> (csr_pkg::MID_QSHIFT + {2'b00, msize_reg[10:8]}));
    poff = cyc.addr - {pbase_reg[15:6], 10'h000};
    per_hit = prog_reg[csr_pkg::P_PBASE] & prog_reg[csr_pkg::P_PMODE]
      & (cyc.io == pmode_reg[csr_pkg::F_IO]) & (poff < csr_pkg::PER_SPAN)
      & ~up_hit & ~lo_hit & ~mid_hit;
    pidx = poff[9:7];
    ctl_h = (cyc.io != reloc_reg[csr_pkg::F_RELOC_MEM]) & (cyc.addr[19:8] == reloc_reg[11:0]);
    nps_hit = enh_mode_reg & enh_reg[csr_pkg::F_ENH_NPS] & cyc.io
      & (cyc.addr >= csr_pkg::NPS_LO) & (cyc.addr <= csr_pkg::NPS_HI);
    hit_any = up_hit | lo_hit | mid_hit | per_hit | nps_hit;
    // wait count and ready mode of the range hit
    if (ctl_h) begin
      w_sel = 2'b00;
      i_sel = 1'b1;
    end else if (up_hit) begin
      w_sel = upper_reg[1:0];
      i_sel = upper_reg[csr_pkg::F_IGN];
    end else if (lo_hit) begin
      w_sel = lower_reg[1:0];
      i_sel = lower_reg[csr_pkg::F_IGN];
    end else if (mid_hit) begin
      w_sel = mbase_reg[1:0];
      i_sel = mbase_reg[csr_pkg::F_IGN];
    end else if (per_hit) begin
      w_sel = pmode_reg[1:0];
      i_sel = pmode_reg[csr_pkg::F_IGN];
    end else begin
      w_sel = 2'b00;
      i_sel = 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mid
      if (gi == 3) begin : g_nps
        assign mid_dec[gi] = enh_mode_reg ? nps_hit : (mid_hit & (midx == 2'(gi)));
      end else begin : g_sel
        assign mid_dec[gi] = mid_hit & (midx == 2'(gi)) & ~(enh_mode_reg & (gi < 2));
      end
    end
    for (gi = 0; gi < 7; gi++) begin : g_per
      assign per_dec[gi] = per_hit & (pidx == 3'(gi));
    end
  endgenerate

  // register read mux
  always_comb begin
    rd = 16'h0000;
    unique case (paddr)
      csr_pkg::REG_UPPER: rd = upper_reg;
      csr_pkg::REG_LOWER: rd = lower_reg;
      csr_pkg::REG_PBASE: rd = pbase_reg;
      csr_pkg::REG_MBASE: rd = mbase_reg;
      csr_pkg::REG_MSIZE: rd = msize_reg;
      csr_pkg::REG_PMODE: rd = pmode_reg;
      csr_pkg::REG_RELOC: rd = reloc_reg;
      csr_pkg::REG_STAT: rd = {11'h000, cp_s2, float_reg, enh_mode_reg, st_reg};
      csr_pkg::REG_ENH: rd = enh_mode_reg ? enh_reg : 16'h0000;
      default: rd = 16'h0000;
    endcase
  end

  assign done_c = (st_reg == csr_pkg::ST_BUSY) & (cnt_reg == 2'b00) & (ign_reg | rdy_s2);

  always_comb begin
    pready_next = psel & ~penable;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel & ~penable) begin
      prdata_next = {16'h0000, rd};
      pslverr_next = (paddr > csr_pkg::REG_ENH) | (paddr[1:0] != 2'b00);
    end
    upper_next = upper_reg;
    lower_next = lower_reg;
    pbase_next = pbase_reg;
    mbase_next = mbase_reg;
    msize_next = msize_reg;
    pmode_next = pmode_reg;
    reloc_next = reloc_reg;
    enh_next = enh_reg;
    prog_next = prog_reg;
    if (wr) begin
      unique case (paddr)
        csr_pkg::REG_UPPER: begin
          upper_next = pwdata[15:0];
          prog_next[csr_pkg::P_UPPER] = 1'b1;
        end
        csr_pkg::REG_LOWER: begin
          lower_next = pwdata[15:0];
          prog_next[csr_pkg::P_LOWER] = 1'b1;
        end
        csr_pkg::REG_PBASE: begin
          pbase_next = pwdata[15:0];
          prog_next[csr_pkg::P_PBASE] = 1'b1;
        end
        csr_pkg::REG_MBASE: begin
          mbase_next = pwdata[15:0];
          prog_next[csr_pkg::P_MBASE] = 1'b1;
        end
        csr_pkg::REG_MSIZE: begin
          msize_next = pwdata[15:0];
          prog_next[csr_pkg::P_MSIZE] = 1'b1;
        end
        csr_pkg::REG_PMODE: begin
          pmode_next = pwdata[15:0];
          prog_next[csr_pkg::P_PMODE] = 1'b1;
        end
        csr_pkg::REG_RELOC: reloc_next = pwdata[15:0];
        csr_pkg::REG_ENH: if (enh_mode_reg) enh_next = pwdata[15:0];
        default: prog_next = prog_reg;
      endcase
    end
    // bus cycle sequencing
    st_next = st_reg;
    cnt_next = cnt_reg;
    ign_next = ign_reg;
    done_next = 1'b0;
    ctl_next = ctl_reg;
    up_next = up_reg;
    lo_next = lo_reg;
    mid_next = mid_reg;
    per_next = per_reg;
    alat_next = alat_reg;
    if ((st_reg == csr_pkg::ST_IDLE) & cyc_start) begin
      st_next = csr_pkg::ST_BUSY;
      cnt_next = w_sel;
      ign_next = i_sel;
      ctl_next = ctl_h;
      up_next = ~(up_hit & ~ctl_h);
      lo_next = ~(lo_hit & ~ctl_h);
      mid_next = ~(mid_dec & {4{~ctl_h}});
      per_next = ~(per_dec & {7{~ctl_h}});
      if (pmode_reg[csr_pkg::F_LATCH]) alat_next = cyc.addr[2:1];
    end else if (st_reg == csr_pkg::ST_BUSY) begin
      if (cnt_reg != 2'b00) begin
        cnt_next = cnt_reg - 2'b01;
      end else if (done_c) begin
        st_next = csr_pkg::ST_IDLE;
        done_next = 1'b1;
        ctl_next = 1'b0;
        up_next = 1'b1;
        lo_next = 1'b1;
        mid_next = 4'hf;
        per_next = 7'h7f;
      end
    end
    // straps and mode detection
    strap_next = 1'b1;
    float_next = float_reg;
    if (~strap_reg) float_next = ~up_s2 & ~lo_s2;
    arm_next = arm_reg | (strap_reg & ~busy_s2);
    enh_mode_next = enh_mode_reg | (arm_reg & busy_s2);
    oe_next = ~float_next;
    cp_oe_next = {2{~float_next & ~enh_mode_next}};
  end

  always_ff @(posedge clk) begin
    up_s1 <= upper_mem_select_n_in;
    up_s2 <= up_s1;
    lo_s1 <= lower_mem_select_n_in;
    lo_s2 <= lo_s1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
      // busy pin idles high on its pull-up; a low reset value would fake a low-then-high edge
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      cp_s1 <= 2'b00;
      cp_s2 <= 2'b00;
      st_reg <= csr_pkg::ST_IDLE;
      upper_reg <= csr_pkg::UPPER_RST;
      lower_reg <= 16'h0000;
      pbase_reg <= 16'h0000;
      mbase_reg <= 16'h0000;
      msize_reg <= 16'h0000;
      pmode_reg <= 16'h0000;
      reloc_reg <= csr_pkg::RELOC_RST;
      enh_reg <= 16'h0000;
      prog_reg <= 6'h01;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      cnt_reg <= 2'b00;
      ign_reg <= 1'b0;
      done_reg <= 1'b0;
      ctl_reg <= 1'b0;
      up_reg <= 1'b1;
      lo_reg <= 1'b1;
      mid_reg <= 4'hf;
      per_reg <= 7'h7f;
      alat_reg <= 2'b00;
      float_reg <= 1'b0;
      strap_reg <= 1'b0;
      arm_reg <= 1'b0;
      enh_mode_reg <= 1'b0;
      oe_reg <= 1'b1;
      cp_oe_reg <= 2'b11;
    end else begin
      rdy_s1 <= ext_ready_in;
      rdy_s2 <= rdy_s1;
      busy_s1 <= coproc_busy_in;
      busy_s2 <= busy_s1;
      cp_s1 <= mid_range_select_n_in[1:0];
      cp_s2 <= cp_s1;
      st_reg <= st_next;
      upper_reg <= upper_next;
      lower_reg <= lower_next;
      pbase_reg <= pbase_next;
      mbase_reg <= mbase_next;
      msize_reg <= msize_next;
      pmode_reg <= pmode_next;
      reloc_reg <= reloc_next;
      enh_reg <= enh_next;
      prog_reg <= prog_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      cnt_reg <= cnt_next;
      ign_reg <= ign_next;
      done_reg <= done_next;
      ctl_reg <= ctl_next;
      up_reg <= up_next;
      lo_reg <= lo_next;
      mid_reg <= mid_next;
      per_reg <= per_next;
      alat_reg <= alat_next;
      float_reg <= float_next;
      strap_reg <= strap_next;
      arm_reg <= arm_next;
      enh_mode_reg <= enh_mode_next;
      oe_reg <= oe_next;
      cp_oe_reg <= cp_oe_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cyc_ready = done_reg;
  assign ctl_hit = ctl_reg;
  assign upper_mem_select_n_out = up_reg;
  assign upper_mem_select_n_oe = oe_reg;
  assign lower_mem_select_n_out = lo_reg;
  assign lower_mem_select_n_oe = oe_reg;
  assign mid_range_select_n_out = mid_reg;
  assign mid_range_select_n_oe = {oe_reg, oe_reg, cp_oe_reg};
  assign periph_select_n = per_reg;
  assign periph_select_oe = oe_reg;
  assign addr_latch = alat_reg;
  assign enhanced = enh_mode_reg;
  assign pin_float_test_mode = float_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic start_ok;
  assign start_ok = (st_reg == csr_pkg::ST_IDLE) & cyc_start;

  waits_zero_a: assert property (start_ok && w_sel == 2'b00 && i_sel |-> ##2 cyc_ready)
    else $error("zero-wait cycle not ready after two cycles");
  waits_three_a: assert property (start_ok && w_sel == 2'b11 |-> ##1 !cyc_ready [*4])
    else $error("three-wait cycle ended early");
  ext_ready_hold_a: assert property (st_reg == csr_pkg::ST_BUSY && !ign_reg && !rdy_s2 |=> !cyc_ready)
    else $error("cycle ended without external ready");
  nohit_quiet_a: assert property (start_ok && !hit_any |=> up_reg && lo_reg && &mid_reg && &per_reg)
    else $error("select asserted for an unmapped access");
  upper_sel_a: assert property (start_ok && up_hit && !ctl_h |=> !upper_mem_select_n_out)
    else $error("upper select missing");
  periph_idx_a: assert property (start_ok && per_hit && !ctl_h |=> periph_select_n == ~(7'h01 << $past(pidx)))
    else $error("wrong peripheral select");
  mid_two_a: assert property (start_ok && mid_hit && midx == 2'b10 && !ctl_h |=> !mid_reg[2])
    else $error("mid select 2 missing");
  enh_lock_a: assert property (!enh_mode_reg && wr && paddr == csr_pkg::REG_ENH |=> $stable(enh_reg))
    else $error("enhanced register written in compatible mode");
  float_hold_a: assert property (float_reg |=> float_reg && !upper_mem_select_n_oe && !periph_select_oe)
    else $error("pin float left before reset");
  enh_pins_a: assert property (enh_mode_reg && !float_reg |-> mid_range_select_n_oe[1:0] == 2'b00)
    else $error("coprocessor inputs driven in enhanced mode");
  sel_single_a: assert property ($countones(~{up_reg, lo_reg, mid_reg, per_reg}) <= 1)
    else $error("more than one select active");

  refresh_c: cover property (start_ok && cyc.refresh && hit_any);
  dma_c: cover property (start_ok && cyc.dma && per_hit);
  ctl_c: cover property (start_ok && ctl_h);
  ext_wait_c: cover property (st_reg == csr_pkg::ST_BUSY && !ign_reg && !rdy_s2 ##1 cyc_ready);
endmodule : csr_top

// ---- sim/csr_far_side.sv ----
// far-side model: memories, peripherals and coprocessor around the select pins.
// assumes the bench owns the strap, coprocessor and slow-ready controls.
module csr_far_side (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cyc_start,
  input wire logic cyc_ready,
  input wire logic slow,
  input wire logic [3:0] dly,
  input wire logic strap_low,
  input wire logic copro,
  input wire logic copro_busy,
  input wire logic [1:0] copro_lines,
  input wire logic up_out,
  input wire logic up_oe,
  input wire logic lo_out,
  input wire logic lo_oe,
  input wire logic [3:0] mid_out,
  input wire logic [3:0] mid_oe,
  output logic ext_ready,
  output logic busy,
  output logic up_in,
  output logic lo_in,
  output logic [3:0] mid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;
  // cycles since the bus cycle began; 4'hf means no cycle in flight
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) cnt_reg <= 4'hf;
    else if (cyc_start) cnt_reg <= 4'h0;
    else if (cyc_ready) cnt_reg <= 4'hf;
    else if (cnt_reg < 4'he) cnt_reg <= cnt_reg + 4'h1;
  end
  // a slow device holds ready low for dly cycles, and never drives it while idle
  assign ext_ready = cnt_reg != 4'hf && (!slow || cnt_reg >= dly);
  // a grounded strap beats the pin driver, else weak pull-ups
  assign up_in = !strap_low && (!up_oe || up_out);
  assign lo_in = !strap_low && (!lo_oe || lo_out);
  // coprocessor drives request and error pin_float_test_mode those pins turn to inputs
  assign mid_in = (mid_oe & mid_out) | (~mid_oe & {2'b11, copro ? copro_lines : 2'b11});
  // without a coprocessor the busy pin sits on its pull-up
  assign busy = copro ? copro_busy : 1'b1;
endmodule : csr_far_side

// ---- sim/tb_top.sv ----
// self-checking bench for the chip-select and ready generator.
// assumes the far-side model answers ready and resolves the select pins.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, psel, penable, pwrite, cyc_start, slow, strap_low, copro, copro_busy, err, enh, nps_en, per_io;
  logic pready, pslverr, cyc_ready, ctl_hit, ext_ready, busy, up_in, up_out, up_oe, lo_in, lo_out, lo_oe;
  logic enhanced, float_mode, per_oe, latch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] addr_latch, copro_lines;
  logic [3:0] mid_in, mid_out, mid_oe, dly;
  logic [4:0] f;
  logic [6:0] per_n;
  logic [12:0] sel;
  logic [2:0] rdy [4];
  logic [9:0] up_start, lo_top;
  logic [19:0] mbase, pbase;
  logic [2:0] mk;
  csr_pkg::csr_cyc_t cyc;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  assign sel = {per_n, mid_out, lo_out, up_out} | {9'h0, enh, enh, 2'h0};
  csr_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc_start(cyc_start), .cyc(cyc),
    .cyc_ready(cyc_ready), .ctl_hit(ctl_hit), .ext_ready_in(ext_ready), .coproc_busy_in(busy),
    .upper_mem_select_n_in(up_in), .upper_mem_select_n_out(up_out), .upper_mem_select_n_oe(up_oe),
    .lower_mem_select_n_in(lo_in), .lower_mem_select_n_out(lo_out), .lower_mem_select_n_oe(lo_oe),
    .mid_range_select_n_in(mid_in), .mid_range_select_n_out(mid_out), .mid_range_select_n_oe(mid_oe),
    .periph_select_n(per_n), .periph_select_oe(per_oe), .addr_latch(addr_latch), .enhanced(enhanced),
    .pin_float_test_mode(float_mode));
  csr_far_side far (.clk(clk), .resetn(resetn), .cyc_start(cyc_start), .cyc_ready(cyc_ready), .slow(slow),
    .dly(dly), .strap_low(strap_low), .copro(copro), .copro_busy(copro_busy), .copro_lines(copro_lines),
    .up_out(up_out), .up_oe(up_oe), .lo_out(lo_out), .lo_oe(lo_oe), .mid_out(mid_out), .mid_oe(mid_oe),
    .ext_ready(ext_ready), .busy(busy), .up_in(up_in), .lo_in(lo_in), .mid_in(mid_in));
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic tally(input logic ok, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : tally
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    tally(g === e, g, e);
  endtask : cmp_reg
  task automatic cmp_pin(input logic [12:0] g, input logic [12:0] e);
    tally(g === e, 32'(g), 32'(e));
  endtask : cmp_pin
  task automatic cmp_cnt(input int n, input int lo, input int hi);
    tally(n >= lo && n <= hi, n, lo);
  endtask : cmp_cnt
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic e_err);
    apb(0, a, 32'h0);
    cmp_reg(rd, e);
    cmp_reg({31'h0, err}, {31'h0, e_err});
  endtask : chk
  // write a register and keep the bench's own copy of the decode setup
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1, a, {16'($urandom), d});
    case (a)
      csr_pkg::REG_UPPER: begin up_start = d[15:6]; rdy[0] = d[2:0]; end
      csr_pkg::REG_LOWER: begin lo_top = d[15:6]; rdy[1] = d[2:0]; f[1] = 1; end
      csr_pkg::REG_PBASE: begin pbase = {d[15:6], 10'h0}; f[0] = 1; end
      csr_pkg::REG_MBASE: begin mbase = {d[15:9], 13'h0}; rdy[2] = d[2:0]; f[2] = 1; end
      csr_pkg::REG_MSIZE: begin mk = d[10:8]; f[3] = 1; end
      csr_pkg::REG_PMODE: begin per_io = d[7]; latch = d[6]; rdy[3] = d[2:0]; f[4] = 1; end
      csr_pkg::REG_ENH: if (enh) nps_en = d[0];
      default: ;
    endcase
  endtask : wr
  // expected {ctl hit, ignore ready, waits, selects} for one bus cycle
  function automatic logic [16:0] exp_of(input logic [19:0] a, input logic io);
    logic [12:0] s;
    logic [2:0] r;
    logic h;
    logic [19:0] msz;
    s = '1;
    r = 3'b000;
    h = 0;
    msz = 20'h02000 << mk;
    if (io && a[19:8] == 12'h0ff) begin h = 1; r = 3'b100; end
    else if (!io && a[19:10] >= up_start) begin s[0] = 0; r = rdy[0]; end
    else if (!io && f[1] && a[19:10] <= lo_top) begin s[1] = 0; r = rdy[1]; end
    else if (!io && f[2] && f[3] && a >= mbase && a < mbase + msz) begin
      s[2 + int'((a - mbase) / (msz >> 2))] = 0;
      r = rdy[2];
    end
    else if (io && enh && nps_en && a[19:3] == 17'h1f) s[5] = 0;
    else if (f[0] && f[4] && io == per_io && a >= pbase && a < pbase + 20'h380) begin
      s[6 + int'((a - pbase) >> 7)] = 0;
      r = rdy[3];
    end
    return {h, r, s};
  endfunction : exp_of
  task automatic bus(input logic [19:0] a, input logic io, input logic sl);
    logic [16:0] e;
    int n;
    int m;
    int lim;
    e = exp_of(a, io);
    // combined ready: device answers dly cycles after start, then two sync stages
    m = int'(e[14:13]) + 2;
    lim = (sl ? int'(dly) : 0) + 4;
    if (lim < m) lim = m;
    @(posedge clk);
    cyc_start <= 1;
    cyc <= '{addr: a, io: io, refresh: 1'($urandom), dma: 1'($urandom)};
    slow <= sl;
    n = 0;
    do begin
      @(posedge clk);
      cyc_start <= 0;
      n++;
      #1;
      if (n == 1) begin
        cmp_pin(sel, e[12:0]);
        cmp_pin({12'h0, ctl_hit}, {12'h0, e[16]});
        if (latch && e[12:6] != 7'h7f) cmp_pin({11'h0, addr_latch}, {11'h0, a[2], a[1]});
      end
    end while (cyc_ready !== 1'b1 && n < 60);
    if (e[15]) cmp_cnt(n, m, m);
    else cmp_cnt(n, lim, lim);
    @(posedge clk);
    #1;
    cmp_pin(sel, '1);
  endtask : bus
  task automatic do_reset(input logic s, input logic c);
    @(posedge clk);
    resetn <= 0;
    strap_low <= s;
    copro <= c;
    copro_busy <= 0;
    enh = 0;
    repeat (6) @(posedge clk);
    #1;
    cmp_pin(sel, '1);
    @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    strap_low <= 0;
    @(posedge clk);
    up_start = 10'h3ff;
    rdy[0] = 3'b011;
    f = '0;
    nps_en = 0;
    latch = 0;
  endtask : do_reset
  task automatic rand_bus();
    logic [19:0] a;
    logic io;
    a = 20'($urandom);
    io = 0;
    case ($urandom % 5)
      0: a = {9'h1ff, a[10:0]};
      1: a = {8'h00, a[11:0]};
      2: a = mbase + (a & ((20'h02000 << mk) - 20'h1));
      3: begin io = per_io; a = pbase + (a % 20'h380); end
      default: io = 1'($urandom);
    endcase
    bus(a, io, 1'($urandom));
  endtask : rand_bus
  initial begin
    resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; cyc_start = 0; cyc = '0;
    slow = 0; strap_low = 0; copro = 0; copro_busy = 0; copro_lines = 2'b00; dly = 4'd6;
    void'($urandom(32'h2157));
    do_reset(0, 0);
    chk(csr_pkg::REG_UPPER, 32'h0000fffb, 0);
    chk(csr_pkg::REG_RELOC, 32'h000000ff, 0);
    chk(csr_pkg::REG_STAT, 32'h00000018, 0);
    chk(8'h24, 32'h0, 1);
    chk(8'h02, 32'h0, 1);
    wr(csr_pkg::REG_ENH, 16'h0001);
    chk(csr_pkg::REG_ENH, 32'h0, 0);
    bus(20'h40000, 0, 1);
    bus(20'h08000, 1, 1);
    bus(20'hffff0, 0, 0);
    bus(20'hffc00, 0, 1);
    bus(20'h0ff10, 1, 0);
    wr(csr_pkg::REG_UPPER, {10'h3fe, 3'h0, 3'($urandom)});
    wr(csr_pkg::REG_LOWER, {10'h003, 3'h0, 3'($urandom)});
    wr(csr_pkg::REG_PBASE, 16'h0800);
    wr(csr_pkg::REG_MBASE, {7'h20, 6'h0, 3'($urandom)});
    wr(csr_pkg::REG_MSIZE, {5'h0, 3'($urandom), 8'h0});
    wr(csr_pkg::REG_PMODE, {8'h0, 1'($urandom), 1'b1, 3'h0, 3'($urandom)});
    bus(20'h00000, 0, 0);
    repeat (60) rand_bus();
    do_reset(1, 0);
    cmp_pin({5'h0, up_oe, lo_oe, mid_oe, per_oe, float_mode}, 13'h001);
    do_reset(0, 0);
    cmp_pin({5'h0, up_oe, lo_oe, mid_oe, per_oe, float_mode}, 13'h0fe);
    do_reset(0, 1);
    copro_lines <= 2'b10;
    repeat (3) @(posedge clk);
    copro_busy <= 1;
    repeat (5) @(posedge clk);
    #1;
    cmp_pin({10'h0, enhanced, mid_oe[1:0]}, 13'h004);
    enh = 1;
    chk(csr_pkg::REG_STAT, 32'h00000012, 0);
    wr(csr_pkg::REG_ENH, 16'h0001);
    chk(csr_pkg::REG_ENH, 32'h1, 0);
    bus(20'h000f8, 1, 0);
    wr(csr_pkg::REG_MBASE, {7'h20, 6'h0, 3'($urandom)});
    wr(csr_pkg::REG_MSIZE, 16'h0000);
    bus(20'h41234, 0, 0);
    conclude();
  end
endmodule : tb_top
